// ==== hdnbu_pkg.sv ====
// Shared constants, register map and types of the nine-bit half-duplex serial port
package hdnbu_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Register indices; one aligned word each
    localparam logic [7:0] SERIAL_DATA_IDX = 8'h00_D6;
    localparam logic [7:0] SERIAL_CONTROL_IDX = 8'h00_D7;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned SERIAL_DATA_ADDR = SERIAL_DATA_IDX * WORD_BYTES;
    localparam int unsigned SERIAL_CONTROL_ADDR = SERIAL_CONTROL_IDX * WORD_BYTES;

    // Control/status bit positions
    localparam int unsigned RX_READY_POS = 7;
    localparam int unsigned TX_EMPTY_POS = 6;
    localparam int unsigned RX_IRQ_EN_POS = 5;
    localparam int unsigned TX_IRQ_EN_POS = 4;
    localparam int unsigned BAUD_SEL_LSB = 1;
    localparam int unsigned NINTH_BIT_POS = 0;

    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00_00;
    localparam logic [7:0] RX_BUFFER_RESET = 8'h00_00;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned OVERSAMPLE = 8;
    localparam int unsigned TICK_CNT_W = 10;
    localparam logic [2:0] BAUD_RESERVED = 3'h7;
    // Internal clock divisors per baud code
    localparam int unsigned BAUD_DIVISOR [0:6] = '{6656, 3328, 1664, 832, 416, 256, 208};
    // Cycles between two oversampling ticks
    localparam int unsigned TICK_CYCLES [0:6] = '{
        BAUD_DIVISOR[0] / OVERSAMPLE, BAUD_DIVISOR[1] / OVERSAMPLE,
        BAUD_DIVISOR[2] / OVERSAMPLE, BAUD_DIVISOR[3] / OVERSAMPLE,
        BAUD_DIVISOR[4] / OVERSAMPLE, BAUD_DIVISOR[5] / OVERSAMPLE,
        BAUD_DIVISOR[6] / OVERSAMPLE};

    // Character framing
    localparam int unsigned FRAME_BITS = 11;
    localparam int unsigned PAYLOAD_BITS = 9;
    localparam logic [2:0] LAST_STATE = 3'h7;
    localparam logic [2:0] SAMPLE_A = 3'h3;
    localparam logic [2:0] SAMPLE_B = 3'h4;
    localparam logic [2:0] SAMPLE_C = 3'h5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic rxReady;
        logic txEmpty;
        logic rxIrqEn;
        logic txIrqEn;
        logic [2:0] baudSel;
        logic ninthBit;
    } hdnbu_ctrl_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } hdnbu_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } hdnbu_rx_state_t;

endpackage

// ==== hdnbu_baud_gen.sv ====
// Oversampling tick generator: eight ticks per bit time
`timescale 1ns/10ps
module hdnbu_baud_gen (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic [2:0] baudSel,
    input wire logic restart,
    // Tick out
    output logic tick
);

    // ------------------------------------------------------------
    // Reload selection
    // ------------------------------------------------------------
    logic [hdnbu_pkg::TICK_CNT_W-1:0] cnt_reg;
    logic [hdnbu_pkg::TICK_CNT_W-1:0] reloadVal;
    logic reserved;
    logic atZero;
    logic tooBig;

    // Reload value follows the select immediately
    always_comb begin
        reloadVal = '0;
        for (int i = 0; i < 7; i++) begin
            if (baudSel == 3'(i)) begin
                reloadVal = hdnbu_pkg::TICK_CNT_W'(hdnbu_pkg::TICK_CYCLES[i] - 1);
            end
        end
    end

    assign reserved = (baudSel == hdnbu_pkg::BAUD_RESERVED);
    assign atZero = (cnt_reg == '0);
    assign tooBig = (cnt_reg > reloadVal);

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    // A raised rate cuts the running count at once, no boundary wait
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart || reserved) begin
            cnt_reg <= reloadVal;
            tick <= 1'b0;
        end else if (atZero) begin
            cnt_reg <= reloadVal;
            tick <= 1'b1; // RULE12
        end else begin
            cnt_reg <= tooBig ? reloadVal : cnt_reg - 1'b1; // RULE18
            tick <= 1'b0;
        end
    end

endmodule

// ==== hdnbu_top.sv ====
// Nine-bit half-duplex asynchronous serial port with AXI4-Lite registers
//
// Notes on behaviour
// RULE1 - Frame is start bit, nine payload bits, one stop bit.
// RULE2 - Ninth bit holds its value until software writes or reception replaces it.
// RULE3 - Data write starts sending: enable output, start 0, eight bits LSB first, ninth.
// RULE4 - Stop bit 1 for one bit time, then output enable drops.
// RULE5 - Finished sending sets empty flag; enabled flag requests interrupt.
// RULE6 - Empty flag cleared by writing 0 or data write; writing 1 sets it.
// RULE7 - Idle receiver waits for falling edge, skips one eight-state start bit.
// RULE8 - Received ninth bit overwrites the ninth-bit control field.
// RULE9 - After nine bits wait stop bit, then move byte to buffer.
// RULE10 - Buffer load sets ready flag; enabled flag requests interrupt.
// RULE11 - Starting a transmission abandons any reception in progress.
// RULE12 - Baud select divides internal clock by printed divisors; code 7 reserved.
// RULE13 - Tick at eight per bit; each bit is two-of-three vote of samples.
// RULE14 - Writing interrupt enables leaves the flags unchanged.
// RULE15 - Reading data register returns receive buffer.
// RULE16 - Software must not read-modify-write the data register.
// RULE17 - Ready flag bit 7 clears on writing 0, sets on writing 1.
// RULE18 - Baud select changes act at once, mid-character included.
// RULE19 - Transmitted data is inverted at the output pin.
// RULE20 - Disabled output follows the port register value, kept high by software.
// RULE21 - Reset clears flags and enables, aborts transfers, drops output enable.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module hdnbu_top #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line
    input wire logic serialInLine,
    input wire logic portBitValue,
    output logic serial_out_line,
    output logic tx_output_enable,
    // Interrupt requests
    output logic txIrqReq,
    output logic rxIrqReq
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 10 || ADDR_W > 32) begin : gBadAddrW
        $error("ADDR_W must cover the register words and fit 32 bits");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hdnbu_pkg::hdnbu_ctrl_t ctrl_reg;
    hdnbu_pkg::hdnbu_tx_state_t txState_reg;
    hdnbu_pkg::hdnbu_rx_state_t rxState_reg;
    logic [7:0] rxBuffer_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic wStrb0_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [10:0] txShift_reg;
    logic [3:0] txBitCnt_reg;
    logic [2:0] txPhase_reg;
    logic [8:0] rxShift_reg;
    logic [3:0] rxBitCnt_reg;
    logic [2:0] rxPhase_reg;
    logic [1:0] voteCnt_reg;
    logic rxSync1_reg;
    logic rxSync2_reg;
    logic rxPrev_reg;
    logic tick;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic doAw;
    logic doW;
    logic doWrite;
    logic doAr;
    logic awHeldNext;
    logic wHeldNext;
    logic bvalidNext;
    logic rvalidNext;
    logic wrData;
    logic wrCtrl;
    logic wrHit;
    logic rdData;
    logic rdCtrl;

    assign doAw = s_axi_awvalid && s_axi_awready;
    assign doW = s_axi_wvalid && s_axi_wready;
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign doAr = s_axi_arvalid && s_axi_arready;
    assign awHeldNext = (awHeld_reg || doAw) && !doWrite;
    assign wHeldNext = (wHeld_reg || doW) && !doWrite;
    assign bvalidNext = doWrite || (s_axi_bvalid && !s_axi_bready);
    assign rvalidNext = doAr || (s_axi_rvalid && !s_axi_rready);
    assign wrHit = (awAddr_reg[1:0] == 2'h0) && wStrb0_reg;
    assign wrData = doWrite && wrHit && (32'(awAddr_reg) == hdnbu_pkg::SERIAL_DATA_ADDR);
    assign wrCtrl = doWrite && wrHit && (32'(awAddr_reg) == hdnbu_pkg::SERIAL_CONTROL_ADDR);
    assign rdData = (32'(s_axi_araddr) == hdnbu_pkg::SERIAL_DATA_ADDR);
    assign rdCtrl = (32'(s_axi_araddr) == hdnbu_pkg::SERIAL_CONTROL_ADDR);

    // Address and data are held until both have arrived
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= 32'h0000_0000;
            wStrb0_reg <= 1'b0;
        end else begin
            awHeld_reg <= awHeldNext;
            wHeld_reg <= wHeldNext;
            if (doAw) begin
                awAddr_reg <= s_axi_awaddr;
            end
            if (doW) begin
                wData_reg <= s_axi_wdata;
                wStrb0_reg <= s_axi_wstrb[0];
            end
        end
    end

    // Handshake outputs, all from flops
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hdnbu_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_awready <= !awHeldNext && !bvalidNext;
            s_axi_wready <= !wHeldNext && !bvalidNext;
            s_axi_bvalid <= bvalidNext;
            if (doWrite) begin
                s_axi_bresp <= (wrData || wrCtrl) ? hdnbu_pkg::RESP_OKAY
                                                 : hdnbu_pkg::RESP_SLVERR;
            end
            s_axi_arready <= !rvalidNext;
            s_axi_rvalid <= rvalidNext;
        end
    end

    // Read data; reads have no side effects
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= hdnbu_pkg::RESP_OKAY;
        end else if (doAr) begin
            s_axi_rdata <= rdData ? {24'h00_0000, rxBuffer_reg} : // RULE15
                           rdCtrl ? {24'h00_0000, ctrl_reg} : 32'h0000_0000;
            s_axi_rresp <= (rdData || rdCtrl) ? hdnbu_pkg::RESP_OKAY
                                             : hdnbu_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Line input and baud ticks
    // ------------------------------------------------------------
    logic txStart;
    logic rxEdge;
    logic rxIdle;
    logic txBusy;

    assign txStart = wrData; // RULE3
    assign txBusy = (txState_reg == hdnbu_pkg::TX_SEND);
    assign rxIdle = (rxState_reg == hdnbu_pkg::RX_IDLE);
    assign rxEdge = rxIdle && !txBusy && !txStart && rxPrev_reg && !rxSync2_reg; // RULE7

    // Two-flop synchroniser then edge history
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxSync1_reg <= 1'b1;
            rxSync2_reg <= 1'b1;
            rxPrev_reg <= 1'b1;
        end else begin
            rxSync1_reg <= serialInLine;
            rxSync2_reg <= rxSync1_reg;
            rxPrev_reg <= rxSync2_reg;
        end
    end

    // Divider restarts to align its phase with each character
    hdnbu_baud_gen u_baud_gen (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .baudSel(ctrl_reg.baudSel),
        .restart(txStart || rxEdge),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic txBitEnd;
    logic txDone;

    assign txBitEnd = txBusy && tick && (txPhase_reg == hdnbu_pkg::LAST_STATE);
    assign txDone = txBitEnd && (txBitCnt_reg == 4'(hdnbu_pkg::FRAME_BITS - 1));

    // Shift out stop, ninth, data, start from the low end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txState_reg <= hdnbu_pkg::TX_IDLE; // RULE21
            txShift_reg <= '1;
            txBitCnt_reg <= 4'h0;
            txPhase_reg <= 3'h0;
        end else if (txStart) begin
            txState_reg <= hdnbu_pkg::TX_SEND;
            txShift_reg <= {1'b1, ctrl_reg.ninthBit, wData_reg[7:0], 1'b0}; // RULE1 RULE3
            txBitCnt_reg <= 4'h0;
            txPhase_reg <= 3'h0;
        end else if (txDone) begin
            txState_reg <= hdnbu_pkg::TX_IDLE; // RULE4
        end else if (txBusy && tick) begin
            txPhase_reg <= txPhase_reg + 3'h1;
            if (txBitEnd) begin
                txShift_reg <= {1'b1, txShift_reg[10:1]};
                txBitCnt_reg <= txBitCnt_reg + 4'h1;
            end
        end
    end

    // Pin: inverted frame while enabled, port value otherwise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_output_enable <= 1'b0; // RULE21
            serial_out_line <= 1'b1;
        end else begin
            tx_output_enable <= txBusy; // RULE4
            serial_out_line <= txBusy ? !txShift_reg[0] : portBitValue; // RULE19 RULE20
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic rxBitEnd;
    logic sampleNow;
    logic votedBit;
    logic rxLoad;

    assign rxBitEnd = tick && (rxPhase_reg == hdnbu_pkg::LAST_STATE);
    assign sampleNow = tick && (rxPhase_reg == hdnbu_pkg::SAMPLE_A ||
                                rxPhase_reg == hdnbu_pkg::SAMPLE_B ||
                                rxPhase_reg == hdnbu_pkg::SAMPLE_C);
    assign votedBit = voteCnt_reg[1]; // RULE13
    assign rxLoad = (rxState_reg == hdnbu_pkg::RX_STOP) && rxBitEnd; // RULE9

    // Start skip, nine voted bits, stop wait
    always_ff @(posedge clk_sys) begin
        if (sys_rst || txStart || txBusy) begin
            rxState_reg <= hdnbu_pkg::RX_IDLE; // RULE11 RULE21
            rxPhase_reg <= 3'h0;
            rxBitCnt_reg <= 4'h0;
            voteCnt_reg <= 2'h0;
            rxShift_reg <= '0;
        end else begin
            unique case (rxState_reg)
                hdnbu_pkg::RX_IDLE: begin
                    rxPhase_reg <= 3'h0;
                    if (rxEdge) begin
                        rxState_reg <= hdnbu_pkg::RX_START;
                    end
                end
                hdnbu_pkg::RX_START: begin
                    if (tick) begin
                        rxPhase_reg <= rxPhase_reg + 3'h1;
                    end
                    if (rxBitEnd) begin
                        rxState_reg <= hdnbu_pkg::RX_DATA; // RULE7
                        rxBitCnt_reg <= 4'h0;
                        voteCnt_reg <= 2'h0;
                    end
                end
                hdnbu_pkg::RX_DATA: begin
                    if (tick) begin
                        rxPhase_reg <= rxPhase_reg + 3'h1;
                    end
                    if (sampleNow && rxSync2_reg && !voteCnt_reg[1]) begin
                        voteCnt_reg <= voteCnt_reg + 2'h1; // RULE13
                    end
                    if (rxBitEnd) begin
                        rxShift_reg <= {votedBit, rxShift_reg[8:1]};
                        rxBitCnt_reg <= rxBitCnt_reg + 4'h1;
                        voteCnt_reg <= 2'h0;
                        if (rxBitCnt_reg == 4'(hdnbu_pkg::PAYLOAD_BITS - 1)) begin
                            rxState_reg <= hdnbu_pkg::RX_STOP;
                        end
                    end
                end
                hdnbu_pkg::RX_STOP: begin
                    if (tick) begin
                        rxPhase_reg <= rxPhase_reg + 3'h1;
                    end
                    if (rxBitEnd) begin
                        rxState_reg <= hdnbu_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive buffer is loaded only at the end of the stop bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rxBuffer_reg <= hdnbu_pkg::RX_BUFFER_RESET;
        end else if (rxLoad) begin
            rxBuffer_reg <= rxShift_reg[7:0]; // RULE9
        end
    end

    // ------------------------------------------------------------
    // Control and status register
    // ------------------------------------------------------------
    logic [7:0] ctrlWr;

    assign ctrlWr = wData_reg[7:0];

    // Hardware sets win over software clears in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_reg <= hdnbu_pkg::CONTROL_RESET; // RULE21
        end else begin
            if (wrCtrl) begin
                ctrl_reg.rxIrqEn <= ctrlWr[hdnbu_pkg::RX_IRQ_EN_POS]; // RULE14
                ctrl_reg.txIrqEn <= ctrlWr[hdnbu_pkg::TX_IRQ_EN_POS]; // RULE14
                ctrl_reg.baudSel <= ctrlWr[hdnbu_pkg::BAUD_SEL_LSB +: 3]; // RULE18
            end
            if (rxLoad) begin
                ctrl_reg.ninthBit <= rxShift_reg[8]; // RULE8
            end else if (wrCtrl) begin
                ctrl_reg.ninthBit <= ctrlWr[hdnbu_pkg::NINTH_BIT_POS]; // RULE2
            end
            if (rxLoad) begin
                ctrl_reg.rxReady <= 1'b1; // RULE10
            end else if (wrCtrl) begin
                ctrl_reg.rxReady <= ctrlWr[hdnbu_pkg::RX_READY_POS]; // RULE17
            end
            if (txDone) begin
                ctrl_reg.txEmpty <= 1'b1; // RULE5
            end else if (wrData) begin
                ctrl_reg.txEmpty <= 1'b0; // RULE6
            end else if (wrCtrl) begin
                ctrl_reg.txEmpty <= ctrlWr[hdnbu_pkg::TX_EMPTY_POS]; // RULE6
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    // Enables only gate the flags onto the request lines
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txIrqReq <= 1'b0;
            rxIrqReq <= 1'b0;
        end else begin
            txIrqReq <= ctrl_reg.txEmpty && ctrl_reg.txIrqEn; // RULE5 RULE14
            rxIrqReq <= ctrl_reg.rxReady && ctrl_reg.rxIrqEn; // RULE10 RULE14
        end
    end

endmodule

// ==== hdnbu_assertions.sv ====
// Port-level checker for the nine-bit serial port
`timescale 1ns/10ps
module hdnbu_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial pins and requests
    input wire logic portBitValue,
    input wire logic serial_out_line,
    input wire logic tx_output_enable,
    input wire logic txIrqReq,
    input wire logic rxIrqReq
);
    logic [11:0] oeCnt;
    // Counts cycles of a frame; bench runs at baud code 6 only
    always_ff @(posedge clk_sys) begin
        oeCnt <= (sys_rst || !tx_output_enable) ? 12'h000 : oeCnt + 12'h001;
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_idle_port: assert property (!tx_output_enable && !$past(sys_rst)
        |-> serial_out_line == $past(portBitValue)) else $error("idle pin not port value");
    a_start_inv: assert property ($rose(tx_output_enable) |-> serial_out_line[*8])
        else $error("start bit not inverted");
    a_stop_level: assert property ($fell(tx_output_enable) |-> !$past(serial_out_line))
        else $error("stop bit level wrong");
    a_frame_len: assert property ($fell(tx_output_enable)
        |-> oeCnt >= 12'h08EE && oeCnt <= 12'h08F3) else $error("frame length wrong");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst
        |=> !tx_output_enable && !txIrqReq && !rxIrqReq) else $error("reset left outputs on");
endmodule

// ==== hdnbu_remote.sv ====
// Remote serial device: sends frames and decodes the port's output
`timescale 1ns/10ps
module hdnbu_remote #(
    parameter int BIT_CYC = 208
) (
    // Clock
    input wire logic clk_sys,
    // Line from the port
    input wire logic serialOut,
    input wire logic outEnable,
    // Line to the port and last character seen
    output logic serialIn,
    output logic [8:0] gotData,
    output logic gotStop
);
    logic [10:0] rxFrame;
    // Line idles at stop level
    initial begin
        serialIn = 1'b1;
        gotData = '0;
        gotStop = 1'b0;
    end
    // Start, nine bits LSB first, stop; fixed rate matches baud code 6
    task automatic send(input logic [8:0] d);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        for (int b = 0; b < 11; b++) begin
            serialIn <= f[b];
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask
    // Samples mid-bit, undoing the pin inversion, ends mid-stop
    initial begin
        forever begin
            @(posedge outEnable);
            for (int b = 0; b < 11; b++) begin
                repeat ((b == 0) ? BIT_CYC / 2 : BIT_CYC) @(posedge clk_sys);
                rxFrame[b] = ~serialOut;
            end
            gotData = rxFrame[9:1];
            gotStop = rxFrame[10];
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the nine-bit serial port
`timescale 1ns/10ps
module testbench;
    localparam logic [11:0] DA = 12'(hdnbu_pkg::SERIAL_DATA_ADDR);
    localparam logic [11:0] CA = 12'(hdnbu_pkg::SERIAL_CONTROL_ADDR);
    localparam logic [1:0] OK = hdnbu_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = hdnbu_pkg::RESP_SLVERR;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic portBit = 1'b1;
    logic [11:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0;
    logic awReady, wReady, bValid, arReady, rValid, txLine, txOe, txIrq, rxIrq, rxLine, gotStop;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [8:0] gotData;
    int n_fail = 0;
    int compares = 0;
    hdnbu_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .serialInLine(rxLine), .portBitValue(portBit), .serial_out_line(txLine),
        .tx_output_enable(txOe), .txIrqReq(txIrq), .rxIrqReq(rxIrq));
    hdnbu_remote #(.BIT_CYC(208)) remote (.clk_sys(clk_sys), .serialOut(txLine),
        .outEnable(txOe), .serialIn(rxLine), .gotData(gotData), .gotStop(gotStop));
    // 40 MHz clock
    initial forever #12.5 clk_sys = ~clk_sys;
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    // Ends the run with counts and verdict
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One bus write or read, answer compared
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
        input logic [1:0] er);
        int i;
        @(posedge clk_sys);
        awAddr <= a;
        arAddr <= a;
        wData <= {24'h00_0000, d};
        awValid <= w;
        wValid <= w;
        bReady <= w;
        arValid <= !w;
        rReady <= !w;
        for (i = 0; i < 64; i++) begin
            @(posedge clk_sys);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (arReady) arValid <= 1'b0;
            if (w ? bValid : rValid) break;
        end
        bReady <= 1'b0;
        rReady <= 1'b0;
        chk(w ? bResp : rResp, er, "bus response");
        if (!w) chk(rData, d, "read data");
        if (i == 64) chk(32'h0, 32'h1, "bus wait ran out");
        if (i == 64) print_verdict();
    endtask
    // Wait for frame end or receive request
    task automatic wait_for(input logic rx);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk_sys);
            if (rx ? rxIrq === 1'b1 : txOe === 1'b0) break;
        end
        if (i == 3000) chk(32'h0, 32'h1, "wait ran out");
        if (i == 3000) print_verdict();
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        xfer(0, CA, 8'h00, OK);
        xfer(0, DA, 8'h00, OK);
        xfer(1, CA + 12'h004, 8'h55, ERR);
        xfer(0, CA + 12'h004, 8'h00, ERR);
        $display("test reset done");
        xfer(1, CA, 8'h1D, OK);
        xfer(0, CA, 8'h1D, OK);
        xfer(1, DA, 8'hA5, OK);
        wait_for(0);
        chk(gotData, 32'h0000_01A5, "sent character");
        chk(gotStop, 32'h0000_0001, "stop bit");
        xfer(0, CA, 8'h5D, OK);
        chk(txIrq, 32'h0000_0001, "tx request");
        xfer(1, CA, 8'h1D, OK);
        xfer(0, CA, 8'h1D, OK);
        chk(txIrq, 32'h0000_0000, "tx request stuck");
        xfer(1, CA, 8'h5D, OK);
        xfer(1, DA, 8'h3C, OK);
        xfer(0, CA, 8'h1D, OK);
        wait_for(0);
        chk(gotData, 32'h0000_013C, "ninth bit kept");
        $display("test transmit done");
        xfer(1, CA, 8'h2C, OK);
        fork
            remote.send(9'h15A);
        join_none
        wait_for(1);
        xfer(0, DA, 8'h5A, OK);
        xfer(0, CA, 8'hAD, OK);
        xfer(1, CA, 8'h2C, OK);
        xfer(0, CA, 8'h2C, OK);
        xfer(1, CA, 8'hAC, OK);
        xfer(0, CA, 8'hAC, OK);
        xfer(1, CA, 8'h2C, OK);
        $display("test receive done");
        fork
            remote.send(9'h0C3);
        join_none
        repeat (832) @(posedge clk_sys);
        xfer(1, DA, 8'h0F, OK);
        wait_for(0);
        xfer(0, CA, 8'h6C, OK);
        xfer(0, DA, 8'h5A, OK);
        chk(gotData, 32'h0000_000F, "sent over reception");
        $display("test priority done");
        print_verdict();
    end
endmodule
bind hdnbu_top hdnbu_assertions u_chk (.*);
